// ### cpe_defines.svh
// Offsets, field positions, reset values and channel masks of the channel power register group
`ifndef CPE_DEFINES_SVH
`define CPE_DEFINES_SVH

// ----------------------------------------
// Register offsets on the control port
// ----------------------------------------
`define CPE_OFF_INPUT_CHANNEL_ENABLES 8'h73
`define CPE_OFF_SERIAL_OUTPUT_SLOT_ENABLES 8'h74
`define CPE_OFF_POWER_CONFIGURATION 8'h75
`define CPE_OFF_CHANNEL_POWER_STATUS 8'h76

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CPE_RST_INPUT_CHANNEL_ENABLES 8'hf0
`define CPE_RST_SERIAL_OUTPUT_SLOT_ENABLES 8'h00
`define CPE_RST_POWER_CONFIGURATION 8'h00
`define CPE_RST_CHANNEL_POWER_STATUS 8'h00

// ----------------------------------------
// Power configuration field positions
// ----------------------------------------
`define CPE_BIT_MIC_BIAS_POWER_ON 7
`define CPE_BIT_CONVERTER_POWER_ON 6
`define CPE_BIT_PLL_POWER_ON 5
`define CPE_BIT_DYNAMIC_CHANNEL_POWER 4
`define CPE_BIT_RANGE_HI 3
`define CPE_BIT_RANGE_LO 2

// ----------------------------------------
// Channel range masks, channel 1 at bit 7
// ----------------------------------------
`define CPE_RANGE_MASK_1_2 8'hc0
`define CPE_RANGE_MASK_1_4 8'hf0
`define CPE_RANGE_MASK_1_6 8'hfc
`define CPE_RANGE_MASK_1_8 8'hff

// Channels 5 to 8 are digital microphone only
`define CPE_PDM_ONLY_MASK 8'h0f

`endif

// ### cpe_pkg.sv
// Types shared by the channel power register group
package cpe_pkg;

   // ----------------------------------------
   // Control port request
   // ----------------------------------------
   typedef struct packed {
      logic wr; // Write strobe
      logic rd; // Read strobe
      logic [7:0] addr; // Register offset
      logic [7:0] wdata; // Write data
   } cpe_req_t;

   // ----------------------------------------
   // Control port answer
   // ----------------------------------------
   typedef struct packed {
      logic valid; // Read data valid pulse
      logic [7:0] rdata; // Read data
   } cpe_rsp_t;

   // ----------------------------------------
   // Dynamic channel range codes
   // ----------------------------------------
   typedef enum logic [1:0] {
      CPE_RANGE_1_2 = 2'h0,
      CPE_RANGE_1_4 = 2'h1,
      CPE_RANGE_1_6 = 2'h2,
      CPE_RANGE_1_8 = 2'h3
   } cpe_range_t;

   // ----------------------------------------
   // Whole state of the block
   // ----------------------------------------
   typedef struct packed {
      logic [7:0] input_channel_enables_reg; // Input channel enables
      logic [7:0] serial_output_slot_enables_reg; // Output slot drives
      logic [7:0] power_configuration_reg; // Power configuration
      logic [7:0] channel_power_status_reg; // Per channel powered state
      logic [7:0] analog_on_reg; // Analog path per channel
      logic rsp_valid_reg; // Read answer pulse
      logic [7:0] rsp_data_reg; // Read answer data
   } cpe_state_t;

endpackage

// ### cpe_channel_power_regs.sv
// Channel enable, output slot enable, power configuration and power status registers
`timescale 1ns/1ps
`include "cpe_defines.svh"

// How it works
// - Eight input enables, channels 1-4 reset on
// - Channels 5-8 never select an analog path
// - Eight output slot drives, zero floats slot
// - Bit 7 powers the mic bias generator
// - Bit 6 powers converter channels, the enabled set at power up from all down
// - Bit 5 powers the PLL
// - Static mode freezes channel power while recording
// - Dynamic mode lets channels change while recording
// - Bits 3-2 choose dynamic channel range
// - Read-only status, one bit per channel
// - Status bit reads one while channel powered
// - Input enables at 0x73, reset F0h
module cpe_channel_power_regs (
   // ----------------------------------------
   // Clock and reset
   // ----------------------------------------
   input wire logic i_clock,
   input wire logic i_arst_n,
   // ----------------------------------------
   // Control port
   // ----------------------------------------
   input wire cpe_pkg::cpe_req_t i_req,
   output cpe_pkg::cpe_rsp_t o_rsp,
   // ----------------------------------------
   // Clock availability from the clock tree
   // ----------------------------------------
   input wire logic i_clock_ok,
   // ----------------------------------------
   // Power and path controls
   // ----------------------------------------
   output logic o_mic_bias_on,
   output logic o_pll_on,
   output logic [7:0] o_channel_power,
   output logic [7:0] o_analog_path_on,
   output logic [7:0] o_slot_drive
);
   import cpe_pkg::*;

   // ----------------------------------------
   // State and decode helpers
   // ----------------------------------------
   cpe_state_t st_reg; // Registered state
   cpe_state_t st_next; // Next state
   logic recording; // Some channel powered
   logic [7:0] range_mask; // Channels under dynamic control
   logic [7:0] target; // Enabled channels allowed up

   // Address match against one register offset
   // Used by both the write and the read decode
   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] off);
      addr_hit = (addr == off);
   endfunction

   // Range code to channel mask
   // Code 3 and any unknown code cover all eight channels
   function automatic logic [7:0] range_to_mask(input logic [1:0] code);
      case (code)
         CPE_RANGE_1_2: range_to_mask = `CPE_RANGE_MASK_1_2;
         CPE_RANGE_1_4: range_to_mask = `CPE_RANGE_MASK_1_4;
         CPE_RANGE_1_6: range_to_mask = `CPE_RANGE_MASK_1_6;
         default: range_to_mask = `CPE_RANGE_MASK_1_8;
      endcase
   endfunction

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   // Registers take host writes, reads answer from the old values,
   // and the powered set is worked out from the registered state.
   // Using registered values everywhere keeps a write and a read in
   // one cycle apart: the read returns what stood before the write.
   // Recording means any channel powered; in static mode the set is
   // frozen while recording, so the host must power all down first.
   always_comb begin
      st_next = st_reg;
      recording = |st_reg.channel_power_status_reg;
      range_mask = range_to_mask(st_reg.power_configuration_reg[`CPE_BIT_RANGE_HI:`CPE_BIT_RANGE_LO]);
      target = st_reg.input_channel_enables_reg;
      st_next.rsp_valid_reg = 1'b0;
      // Register writes
      if (i_req.wr) begin
         if (addr_hit(i_req.addr, `CPE_OFF_INPUT_CHANNEL_ENABLES)) begin
            st_next.input_channel_enables_reg = i_req.wdata;
         end
         if (addr_hit(i_req.addr, `CPE_OFF_SERIAL_OUTPUT_SLOT_ENABLES)) begin
            st_next.serial_output_slot_enables_reg = i_req.wdata;
         end
         if (addr_hit(i_req.addr, `CPE_OFF_POWER_CONFIGURATION)) begin
            st_next.power_configuration_reg = i_req.wdata;
         end
         // Status offset takes no write
      end
      // Register reads, unmapped offsets answer zero
      // The answer pulse lasts one cycle, the data stands until the next read
      if (i_req.rd) begin
         st_next.rsp_valid_reg = 1'b1;
         if (addr_hit(i_req.addr, `CPE_OFF_INPUT_CHANNEL_ENABLES)) begin
            st_next.rsp_data_reg = st_reg.input_channel_enables_reg;
         end else if (addr_hit(i_req.addr, `CPE_OFF_SERIAL_OUTPUT_SLOT_ENABLES)) begin
            st_next.rsp_data_reg = st_reg.serial_output_slot_enables_reg;
         end else if (addr_hit(i_req.addr, `CPE_OFF_POWER_CONFIGURATION)) begin
            st_next.rsp_data_reg = st_reg.power_configuration_reg;
         end else if (addr_hit(i_req.addr, `CPE_OFF_CHANNEL_POWER_STATUS)) begin
            st_next.rsp_data_reg = st_reg.channel_power_status_reg;
         end else begin
            st_next.rsp_data_reg = 8'h00;
         end
      end
      // Channel power state
      // Priority: converter off, then clock loss, then power up from all down,
      // then dynamic or static handling while some channel records
      if (!st_reg.power_configuration_reg[`CPE_BIT_CONVERTER_POWER_ON]) begin
         st_next.channel_power_status_reg = 8'h00;
      end else if (!i_clock_ok) begin
         st_next.channel_power_status_reg = 8'h00;
      end else if (!recording) begin
         st_next.channel_power_status_reg = target;
      end else if (st_reg.power_configuration_reg[`CPE_BIT_DYNAMIC_CHANNEL_POWER]) begin
         // In range follows enables, out of range stays put
         st_next.channel_power_status_reg = (target & range_mask) |
            (st_reg.channel_power_status_reg & ~range_mask);
      end else begin
         // Static mode: set frozen while recording
         st_next.channel_power_status_reg = st_reg.channel_power_status_reg;
      end
      // Analog paths only for channels 1 to 4
      // Taken from the next powered set so both outputs move on one edge
      st_next.analog_on_reg = st_next.channel_power_status_reg & ~`CPE_PDM_ONLY_MASK;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   // Reset loads the reset values field by field; only constants here
   // so the asynchronous path stays a plain set or clear of each flop
   always_ff @(posedge i_clock or negedge i_arst_n) begin
      if (!i_arst_n) begin
         st_reg.input_channel_enables_reg <= `CPE_RST_INPUT_CHANNEL_ENABLES;
         st_reg.serial_output_slot_enables_reg <= `CPE_RST_SERIAL_OUTPUT_SLOT_ENABLES;
         st_reg.power_configuration_reg <= `CPE_RST_POWER_CONFIGURATION;
         st_reg.channel_power_status_reg <= `CPE_RST_CHANNEL_POWER_STATUS;
         st_reg.analog_on_reg <= 8'h00;
         st_reg.rsp_valid_reg <= 1'b0;
         st_reg.rsp_data_reg <= 8'h00;
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------
   // Outputs straight from state
   // ----------------------------------------
   // Every output is a flop of the state, so no decode glitch reaches a pin
   assign o_rsp.valid = st_reg.rsp_valid_reg;
   assign o_rsp.rdata = st_reg.rsp_data_reg;
   assign o_mic_bias_on = st_reg.power_configuration_reg[`CPE_BIT_MIC_BIAS_POWER_ON];
   assign o_pll_on = st_reg.power_configuration_reg[`CPE_BIT_PLL_POWER_ON];
   assign o_channel_power = st_reg.channel_power_status_reg;
   assign o_analog_path_on = st_reg.analog_on_reg;
   assign o_slot_drive = st_reg.serial_output_slot_enables_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_arst_n);

   // Checks read the registered state, so each one names the cycle
   // after the cause with |=> or looks back with $past where the
   // cause itself is needed; the two analog path checks need neither.

   // Per channel: powered implies enabled the cycle before or already powered before
   for (genvar ch = 0; ch < 8; ch++) begin : g_chk
      powered_cause_a: assert property (
         o_channel_power[ch] |-> $past(st_reg.input_channel_enables_reg[ch]) || $past(o_channel_power[ch]))
         else $error("channel powered without enable");
   end

   // ----------------------------------------
   // Register write checks
   // ----------------------------------------
   // A slot write shows on the drive outputs one cycle later
   slot_write_a: assert property (
      i_req.wr && i_req.addr == `CPE_OFF_SERIAL_OUTPUT_SLOT_ENABLES |=> o_slot_drive == $past(i_req.wdata))
      else $error("slot drive not updated by write");
   // Without a slot write the drives hold
   slot_hold_a: assert property (
      !(i_req.wr && i_req.addr == `CPE_OFF_SERIAL_OUTPUT_SLOT_ENABLES) |=> $stable(o_slot_drive))
      else $error("slot drive changed without write");
   // An enable write lands in the register one cycle later
   enable_write_a: assert property (
      i_req.wr && i_req.addr == `CPE_OFF_INPUT_CHANNEL_ENABLES
      |=> st_reg.input_channel_enables_reg == $past(i_req.wdata))
      else $error("input enables not updated by write");
   // Without an enable write the enables hold
   enable_hold_a: assert property (
      !(i_req.wr && i_req.addr == `CPE_OFF_INPUT_CHANNEL_ENABLES)
      |=> $stable(st_reg.input_channel_enables_reg))
      else $error("input enables changed without write");
   // Configuration keeps every written bit, the reserved pair too
   cfg_write_a: assert property (
      i_req.wr && i_req.addr == `CPE_OFF_POWER_CONFIGURATION
      |=> st_reg.power_configuration_reg == $past(i_req.wdata))
      else $error("power configuration not updated by write");
   // A status write leaves every writable register alone
   status_nowrite_a: assert property (
      i_req.wr && i_req.addr == `CPE_OFF_CHANNEL_POWER_STATUS
      |=> $stable(st_reg.input_channel_enables_reg) && $stable(st_reg.serial_output_slot_enables_reg) &&
      $stable(st_reg.power_configuration_reg))
      else $error("status write changed a register");
   // Bias and PLL follow their configuration bits
   bias_pll_a: assert property (
      i_req.wr && i_req.addr == `CPE_OFF_POWER_CONFIGURATION
      |=> o_mic_bias_on == $past(i_req.wdata[`CPE_BIT_MIC_BIAS_POWER_ON]) &&
      o_pll_on == $past(i_req.wdata[`CPE_BIT_PLL_POWER_ON]))
      else $error("bias or pll control mismatch");
   // Without a configuration write bias and PLL hold
   bias_pll_hold_a: assert property (
      !(i_req.wr && i_req.addr == `CPE_OFF_POWER_CONFIGURATION)
      |=> $stable(o_mic_bias_on) && $stable(o_pll_on))
      else $error("bias or pll changed without write");

   // ----------------------------------------
   // Channel power checks
   // ----------------------------------------
   // Converter control low forces every channel down
   conv_off_a: assert property (
      !st_reg.power_configuration_reg[`CPE_BIT_CONVERTER_POWER_ON] |=> o_channel_power == 8'h00)
      else $error("channel powered with converter off");
   // Losing the converter clock forces every channel down
   clock_loss_a: assert property (!i_clock_ok |=> o_channel_power == 8'h00)
      else $error("channel powered without clock");
   // From all down, power up copies the enables
   startup_a: assert property (
      st_reg.power_configuration_reg[`CPE_BIT_CONVERTER_POWER_ON] && i_clock_ok && o_channel_power == 8'h00
      |=> o_channel_power == $past(st_reg.input_channel_enables_reg))
      else $error("power up did not follow enables");
   // Static mode: the recording set holds
   static_hold_a: assert property (
      st_reg.power_configuration_reg[`CPE_BIT_CONVERTER_POWER_ON] && i_clock_ok && o_channel_power != 8'h00 &&
      !st_reg.power_configuration_reg[`CPE_BIT_DYNAMIC_CHANNEL_POWER] |=> $stable(o_channel_power))
      else $error("channel power changed in static mode");
   // Dynamic mode: channels inside the range follow their enables
   dyn_range_a: assert property (
      st_reg.power_configuration_reg[`CPE_BIT_CONVERTER_POWER_ON] && i_clock_ok && o_channel_power != 8'h00 &&
      st_reg.power_configuration_reg[`CPE_BIT_DYNAMIC_CHANNEL_POWER]
      |=> ((o_channel_power ^ $past(st_reg.input_channel_enables_reg)) & $past(range_mask)) == 8'h00)
      else $error("dynamic channel did not follow enable");
   // Dynamic mode: channels outside the range keep their state
   dyn_outside_a: assert property (
      st_reg.power_configuration_reg[`CPE_BIT_CONVERTER_POWER_ON] && i_clock_ok && o_channel_power != 8'h00 &&
      st_reg.power_configuration_reg[`CPE_BIT_DYNAMIC_CHANNEL_POWER]
      |=> ((o_channel_power ^ $past(o_channel_power)) & ~$past(range_mask)) == 8'h00)
      else $error("channel outside range changed");
   // Channels 5 to 8 never get an analog path
   pdm_only_a: assert property ((o_analog_path_on & `CPE_PDM_ONLY_MASK) == 8'h00)
      else $error("analog path on a digital only channel");
   // Channels 1 to 4 get an analog path exactly while powered
   analog_follow_a: assert property (
      o_analog_path_on == (o_channel_power & ~`CPE_PDM_ONLY_MASK))
      else $error("analog path does not follow power");

   // ----------------------------------------
   // Read path checks
   // ----------------------------------------
   // Every read answers one cycle later
   read_pulse_a: assert property (i_req.rd |=> o_rsp.valid)
      else $error("read gave no answer");
   // No answer appears without a read
   valid_cause_a: assert property (o_rsp.valid |-> $past(i_req.rd))
      else $error("answer without a read");
   // Read data holds between reads
   rdata_hold_a: assert property (!i_req.rd |=> $stable(o_rsp.rdata))
      else $error("read data changed without a read");
   // Status read returns the powered set
   read_status_a: assert property (
      i_req.rd && i_req.addr == `CPE_OFF_CHANNEL_POWER_STATUS
      |=> o_rsp.valid && o_rsp.rdata == $past(o_channel_power))
      else $error("status read mismatch");
   // Enable read returns the stored enables
   read_enables_a: assert property (
      i_req.rd && i_req.addr == `CPE_OFF_INPUT_CHANNEL_ENABLES
      |=> o_rsp.rdata == $past(st_reg.input_channel_enables_reg))
      else $error("enable read mismatch");
   // Configuration read returns every stored bit
   read_config_a: assert property (
      i_req.rd && i_req.addr == `CPE_OFF_POWER_CONFIGURATION
      |=> o_rsp.rdata == $past(st_reg.power_configuration_reg))
      else $error("configuration read mismatch");
   // Slot read returns the stored drives
   read_slots_a: assert property (
      i_req.rd && i_req.addr == `CPE_OFF_SERIAL_OUTPUT_SLOT_ENABLES
      |=> o_rsp.rdata == $past(st_reg.serial_output_slot_enables_reg))
      else $error("slot read mismatch");

   // Main scenarios
   cov_record_c: cover property (o_channel_power == 8'h00 ##1 o_channel_power != 8'h00);
   cov_dyn_change_c: cover property (o_channel_power != 8'h00 ##1 $changed(o_channel_power) &&
      o_channel_power != 8'h00);
   cov_clock_loss_c: cover property (o_channel_power != 8'h00 ##1 !i_clock_ok ##1 o_channel_power == 8'h00);
   cov_read_c: cover property (i_req.rd ##1 o_rsp.valid);
   cov_status_write_c: cover property (i_req.wr && i_req.addr == `CPE_OFF_CHANNEL_POWER_STATUS);

endmodule

// ### channel_power_enable_regs_test.sv
// Self-checking bench for the channel power register group
`timescale 1ns/1ps
module channel_power_enable_regs_test;
   import cpe_pkg::*;
   // ----------------------------------------
   // Bench signals
   // ----------------------------------------
   logic i_clock = 1'b0; // 10 MHz clock
   logic i_arst_n = 1'b0; // Reset, active low
   cpe_req_t i_req = '0; // Control port request
   cpe_rsp_t o_rsp; // Control port answer
   logic i_clock_ok = 1'b1; // Converter clock present
   logic o_mic_bias_on; // Bias generator power
   logic o_pll_on; // PLL power
   logic [7:0] o_channel_power; // Powered channels
   logic [7:0] o_analog_path_on; // Analog paths
   logic [7:0] o_slot_drive; // Output slot drives
   int failures = 0; // Mismatch count
   int checked = 0; // Comparison count
   logic [7:0] lfsr_reg = 8'h2a; // Random source, starts at 42
   logic [7:0] a; // First enable pattern
   logic [7:0] b; // Second enable pattern
   cpe_channel_power_regs DUT (
      .i_clock(i_clock), .i_arst_n(i_arst_n), .i_req(i_req), .o_rsp(o_rsp), .i_clock_ok(i_clock_ok),
      .o_mic_bias_on(o_mic_bias_on), .o_pll_on(o_pll_on), .o_channel_power(o_channel_power),
      .o_analog_path_on(o_analog_path_on), .o_slot_drive(o_slot_drive));
   // Clock, 100 ns period
   always #50 i_clock = ~i_clock;
   // ----------------------------------------
   // Expectation helpers
   // ----------------------------------------
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // Channels covered by each dynamic range code
   function automatic logic [7:0] range_mask(input logic [1:0] r);
      case (r)
         2'h0: return 8'hc0;
         2'h1: return 8'hf0;
         2'h2: return 8'hfc;
         default: return 8'hff;
      endcase
   endfunction
   // In-range channels follow enables, others hold
   function automatic logic [7:0] dyn_expect(input logic [7:0] old, input logic [7:0] en, input logic [1:0] r);
      return (en & range_mask(r)) | (old & ~range_mask(r));
   endfunction
   // ----------------------------------------
   // Bus and check tasks
   // ----------------------------------------
   task automatic rnd();
      lfsr_reg = lfsr_next(lfsr_reg);
   endtask
   task automatic compare(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wait_edges(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask
   // One-cycle write strobe, effect visible after the taking edge
   task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
      @(posedge i_clock);
      i_req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
      @(posedge i_clock);
      i_req <= '0;
      #1;
   endtask
   // Read: answer pulse stands for the cycle after the taking edge
   task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp, input string what);
      @(posedge i_clock);
      i_req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
      @(posedge i_clock);
      i_req <= '0;
      #1;
      compare("read valid", 8'h01, {7'h0, o_rsp.valid});
      compare(what, exp, o_rsp.rdata);
      wait_edges(1);
      compare("valid drop", 8'h00, {7'h0, o_rsp.valid});
   endtask
   task automatic wrap_up();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (2) @(posedge i_clock);
      i_arst_n <= 1'b1;
      #1;
      compare("outputs", 8'h00, o_channel_power | o_slot_drive | o_analog_path_on);
      compare("bias pll", 8'h00, {6'h0, o_mic_bias_on, o_pll_on});
      reg_read(8'h73, 8'hf0, "input enables");
      reg_read(8'h74, 8'h00, "slot enables");
      reg_read(8'h75, 8'h00, "power cfg");
      reg_read(8'h76, 8'h00, "status");
      $display("test reset done");
      // Random slot drives, bias, PLL and reserved bits
      for (int i = 0; i < 8; i++) begin
         rnd();
         reg_write(8'h74, lfsr_reg);
         compare("slot drive", lfsr_reg, o_slot_drive);
         reg_read(8'h74, lfsr_reg, "slot readback");
         a = lfsr_reg & 8'hbf;
         reg_write(8'h75, a);
         compare("bias pll", {6'h0, a[7], a[5]}, {6'h0, o_mic_bias_on, o_pll_on});
         reg_read(8'h75, a, "power cfg readback");
      end
      reg_write(8'h76, 8'hff);
      reg_read(8'h76, 8'h00, "status write");
      reg_read(8'h3c, 8'h00, "unmapped");
      $display("test registers done");
      // Static mode: power up, hold while recording, clock loss
      rnd();
      a = lfsr_reg | 8'h81;
      reg_write(8'h73, a);
      reg_write(8'h75, 8'h40);
      wait_edges(1);
      compare("power up", a, o_channel_power);
      compare("analog path", a & 8'hf0, o_analog_path_on);
      reg_read(8'h76, a, "status");
      // Static mode: host leaves the enables alone while recording
      reg_write(8'h74, ~a);
      wait_edges(2);
      compare("static hold", a, o_channel_power);
      @(posedge i_clock);
      i_clock_ok <= 1'b0;
      wait_edges(2);
      compare("clock loss", 8'h00, o_channel_power);
      // All channels down, so the enables may change now
      reg_write(8'h73, ~a);
      @(posedge i_clock);
      i_clock_ok <= 1'b1;
      wait_edges(2);
      compare("repower", ~a, o_channel_power);
      reg_write(8'h75, 8'h00);
      wait_edges(1);
      compare("power down", 8'h00, o_channel_power);
      $display("test static done");
      // Dynamic mode, every range code
      for (int r = 0; r < 4; r++) begin
         rnd();
         a = lfsr_reg | 8'h80;
         rnd();
         b = lfsr_reg;
         reg_write(8'h75, 8'h00);
         reg_write(8'h73, a);
         reg_write(8'h75, 8'h50 | {4'h0, r[1:0], 2'h0});
         wait_edges(1);
         compare("dyn start", a, o_channel_power);
         reg_write(8'h73, b);
         wait_edges(1);
         compare("dyn change", dyn_expect(a, b, r[1:0]), o_channel_power);
         compare("dyn analog", dyn_expect(a, b, r[1:0]) & 8'hf0, o_analog_path_on);
      end
      $display("test dynamic done");
      wrap_up();
   end
   // Watchdog, far beyond the fewer than two hundred cycles the tests need
   initial begin
      #1000000;
      failures++;
      wrap_up();
   end
endmodule
